// >>> iqd_consts.vh
`ifndef IQD_CONSTS_VH
`define IQD_CONSTS_VH
`define IQD_A_CTRL     6'h00
`define IQD_A_VECT     6'h01
`define IQD_A_MASK     6'h02
`define IQD_A_PRIO     6'h03
`define IQD_A_RXADDR   6'h04
`define IQD_A_RXCNT    6'h05
`define IQD_A_TXADDR   6'h06
`define IQD_A_TXCNT    6'h07
`define IQD_A_STAT     6'h08
`define IQD_B_GATE     0
`define IQD_B_TXM      0
`define IQD_B_RXM      1
`define IQD_B_ERRM     2
`define IQD_B_TXDMA    3
`define IQD_B_RXDMA    4
`define IQD_B_TXEOB    5
`define IQD_B_RXEOB    6
`define IQD_B_TXP      3
`define IQD_B_RXP      4
`define IQD_B_ERRP     5
`define IQD_B_SUSP     7
`define IQD_B_TGT      31
`define IQD_PRL_OFF    3'h7
`define IQD_PRL_RST    3'h0
`define IQD_VEC_ERR    3'h2
`define IQD_VEC_RX     3'h4
`define IQD_VEC_TX     3'h6
`define IQD_VEC_RST    5'h00
`define IQD_RF_MAX     17'h000DE
`define IQD_MEM_MAX    17'h10000
`define IQD_CNT_ZERO   17'h00000
`define IQD_CNT_ONE    17'h00001
`define IQD_ADDR_ONE   16'h0001
`endif

// >>> iqd_dma_partner.sv
module iqd_dma_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       dma_req,
  input  wire logic [3:0] ack_delay,
  input  wire logic [7:0] fetch_byte,
  output logic            dma_ack,
  output logic [7:0]      dma_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // Outside the acknowledge cycle the bus shows the inverse, so a late sample is caught.
  assign dma_rdata = dma_ack ? fetch_byte : ~fetch_byte;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      dma_ack  <= 1'b0;
    end else if (!dma_req || dma_ack) begin
      wait_cnt <= 4'h0;
      dma_ack  <= 1'b0;
    end else if (wait_cnt >= ack_delay) begin
      dma_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// >>> iqd_irq_dma.v
// How it works
// - Three sources exist: error condition, data received, ready to transmit.
// - Flag-driven interrupts need the global gate bit in the control register.
// - Any-event flag follows every event except the end-of-block ones.
// - Data received is raised when byte finished and direction is receive.
// - With receive DMA enabled, received bytes go to DMA; its vector marks end-of-block.
// - Ready to transmit is raised when byte finished and direction is send.
// - With transmit DMA enabled, transmit bytes come by DMA; its vector marks end-of-block.
// - Error source rises on any of the nine error and status event flags.
// - Vector is five programmed high bits plus 010, 100 or 110.
// - Priority level all ones never requests an interrupt, but DMA still requests; all zeros is highest.
// - Fixed internal order: error, then data received, then ready to transmit.
// - Events set pending bits; requests need the mask bit and a usable level.
// - Only software clears pending bits; a pending unmasked bit keeps requesting.
// - Error pending is held high while any error event flag is set and the global gate bit is on.
// - Suspend bit set and error pending stop DMA; else DMA outranks interrupts.
// - End-of-block interrupts share vector and priority of their direction source.
// - Counts reach 222 for register file targets and 65536 for memory.
// - Each transfer moves one byte, increments the address, decrements the count.
// - Receive and transmit DMA have separate enable bits in the mask register.
// - Count reaching zero sets that direction's end-of-block pending bit.
// - End-of-block interrupts ignore the global gate bit.
// - DMA requests carry the same priority level as the interrupts.
// - Counter pointer bit selects register file when set, memory when clear.
// - The clock line is held low while a needed DMA transfer is unfinished.
`include "iqd_consts.vh"
module iqd_irq_dma (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        byte_finished_flag,
  input  wire        direction_send_flag,
  input  wire        slave_match_flag,
  input  wire        start_sent_flag,
  input  wire        no_ack_flag,
  input  wire        stop_seen_flag,
  input  wire        lost_bus_flag,
  input  wire        bus_fault_flag,
  input  wire        header_sent_flag,
  input  wire        master_addr_sent_flag,
  input  wire        clock_line_flag,
  input  wire [7:0]  rx_byte,
  output reg  [7:0]  tx_byte,
  output reg         dma_byte_done,
  output wire        scl_hold,
  output reg         any_event_flag,
  output wire        irq_req,
  output reg  [7:0]  irq_vector,
  output wire [2:0]  irq_level,
  output wire        dma_req,
  output reg         dma_write,
  output reg         dma_to_regfile,
  output reg  [15:0] dma_addr,
  output reg  [7:0]  dma_wdata,
  output wire [2:0]  dma_level,
  input  wire        dma_ack,
  input  wire [7:0]  dma_rdata
);

  reg        irq_global_gate_reg;
  reg [4:0]  vector_reg;
  reg        tx_mask_reg;
  reg        rx_mask_reg;
  reg        error_mask_reg;
  reg        tx_dma_enable_reg;
  reg        rx_dma_enable_reg;
  reg        tx_end_block_pending_reg;
  reg        rx_end_block_pending_reg;
  reg [2:0]  priority_level_field_reg;
  reg        tx_pending_reg;
  reg        rx_pending_reg;
  reg        error_pending_reg;
  reg        dma_suspend_on_error_reg;
  reg [15:0] rx_addr_reg;
  reg [16:0] rx_cnt_reg;
  reg        rx_tgt_reg;
  reg [15:0] tx_addr_reg;
  reg [16:0] tx_cnt_reg;
  reg        tx_tgt_reg;
  reg        rx_cond_reg;
  reg        tx_cond_reg;
  reg        rx_need_reg;
  reg        tx_need_reg;
  reg        busy_reg;
  reg        busy_rx_reg;
  reg [31:0] rd_word;

  wire [5:0] idx;
  wire       wr;
  wire       rd;
  wire       mapped;
  wire       rx_cond;
  wire       tx_cond;
  wire       rx_evt;
  wire       tx_evt;
  wire       err_flags;
  wire       err_set;
  wire       rx_set;
  wire       tx_set;
  wire       err_act;
  wire       rx_act;
  wire       tx_act;
  wire       dma_ok;
  wire       dma_start;
  wire       dma_end;
  wire       last_rx;
  wire       last_tx;

  // A count of zero in memory mode means a full block, so the counter is one bit wider.
  function [16:0] cnt_load;
    input        tgt;
    input [15:0] d;
    begin
      if (tgt) begin
        if ({9'h000, d[7:0]} > `IQD_RF_MAX)
          cnt_load = `IQD_RF_MAX;
        else
          cnt_load = {9'h000, d[7:0]};
      end else if (d == 16'h0000) begin
        cnt_load = `IQD_MEM_MAX;
      end else begin
        cnt_load = {1'b0, d};
      end
    end
  endfunction

  // Pending bits follow the written value, but a hardware set wins over a clear.
  function pend_next;
    input cur;
    input we;
    input wd;
    input set;
    begin
      pend_next = (we ? wd : cur) | set;
    end
  endfunction

  // Unmapped or unaligned accesses must not alias onto a real register, so they are refused whole.
  assign idx     = paddr[7:2];
  assign wr      = psel & penable & pwrite & mapped;
  assign rd      = psel & ~penable & ~pwrite;
  assign mapped  = (idx <= `IQD_A_STAT) && (paddr[1:0] == 2'b00);
  assign pready  = 1'b1;
  // The error answer is given in the access phase only, together with the ready that ends it.
  assign pslverr = psel & penable & ~mapped;

  assign rx_cond   = byte_finished_flag & ~direction_send_flag;
  assign tx_cond   = byte_finished_flag & direction_send_flag;
  // The byte-finished flag is a level; only its rising edge counts, so one byte raises one event.
  assign rx_evt    = rx_cond & ~rx_cond_reg;
  assign tx_evt    = tx_cond & ~tx_cond_reg;
  assign err_flags = slave_match_flag | start_sent_flag | no_ack_flag | stop_seen_flag |
                     lost_bus_flag | bus_fault_flag | header_sent_flag | master_addr_sent_flag |
                     clock_line_flag;

  // The forced level covers the edge, so no separate error edge detector is kept.
  assign err_set = irq_global_gate_reg & err_flags;
  assign rx_set  = irq_global_gate_reg & rx_evt & ~rx_dma_enable_reg;
  assign tx_set  = irq_global_gate_reg & tx_evt & ~tx_dma_enable_reg;

  // Masks gate requests only; pending bits still record events while masked.
  assign err_act = error_pending_reg & error_mask_reg;
  assign rx_act  = rx_mask_reg & (rx_pending_reg | rx_end_block_pending_reg);
  assign tx_act  = tx_mask_reg & (tx_pending_reg | tx_end_block_pending_reg);

  // A suspended transfer keeps its address and data and resumes where it stopped.
  assign dma_ok    = ~(dma_suspend_on_error_reg & error_pending_reg);
  assign dma_req   = busy_reg & dma_ok;
  assign dma_level = priority_level_field_reg;
  assign irq_level = priority_level_field_reg;
  assign dma_start = ~busy_reg & (rx_need_reg | tx_need_reg);
  assign dma_end   = dma_req & dma_ack;
  assign last_rx   = dma_end & busy_rx_reg & (rx_cnt_reg == `IQD_CNT_ONE);
  assign last_tx   = dma_end & ~busy_rx_reg & (tx_cnt_reg == `IQD_CNT_ONE);

  // DMA outranks every source unless suspended, in which case error still goes first.
  assign irq_req = (priority_level_field_reg != `IQD_PRL_OFF) &
                   (err_act | ((rx_act | tx_act) & ~dma_req)) &
                   ~(dma_req & ~dma_suspend_on_error_reg);

  assign scl_hold = rx_need_reg | tx_need_reg | busy_reg;

  // The vector keeps the fixed order even while DMA holds the request off, so software sees a steady code.
  always @* begin
    if (err_act)
      irq_vector = {vector_reg, `IQD_VEC_ERR};
    else if (rx_act)
      irq_vector = {vector_reg, `IQD_VEC_RX};
    else
      irq_vector = {vector_reg, `IQD_VEC_TX};
  end

  always @* begin
    case (idx)
      `IQD_A_CTRL:
        rd_word = {31'h00000000, irq_global_gate_reg};
      `IQD_A_VECT:
        rd_word = {24'h000000, vector_reg, 3'h0};
      `IQD_A_MASK:
        rd_word = {25'h0000000, rx_end_block_pending_reg, tx_end_block_pending_reg,
                   rx_dma_enable_reg, tx_dma_enable_reg, error_mask_reg, rx_mask_reg, tx_mask_reg};
      `IQD_A_PRIO:
        rd_word = {24'h000000, dma_suspend_on_error_reg, 1'b0, error_pending_reg, rx_pending_reg,
                   tx_pending_reg, priority_level_field_reg};
      `IQD_A_RXADDR:
        rd_word = {16'h0000, rx_addr_reg};
      `IQD_A_RXCNT:
        rd_word = {rx_tgt_reg, 14'h0000, rx_cnt_reg};
      `IQD_A_TXADDR:
        rd_word = {16'h0000, tx_addr_reg};
      `IQD_A_TXCNT:
        rd_word = {tx_tgt_reg, 14'h0000, tx_cnt_reg};
      `IQD_A_STAT:
        rd_word = {28'h0000000, busy_reg, tx_need_reg, rx_need_reg, any_event_flag};
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup phase, so a registered word stands through the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      if (mapped)
        prdata <= rd_word;
      else
        prdata <= 32'h00000000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_global_gate_reg      <= 1'b0;
      vector_reg               <= `IQD_VEC_RST;
      tx_mask_reg              <= 1'b0;
      rx_mask_reg              <= 1'b0;
      error_mask_reg           <= 1'b0;
      tx_dma_enable_reg        <= 1'b0;
      rx_dma_enable_reg        <= 1'b0;
      tx_end_block_pending_reg <= 1'b0;
      rx_end_block_pending_reg <= 1'b0;
      priority_level_field_reg <= `IQD_PRL_RST;
      tx_pending_reg           <= 1'b0;
      rx_pending_reg           <= 1'b0;
      error_pending_reg        <= 1'b0;
      dma_suspend_on_error_reg <= 1'b1;
      rx_addr_reg              <= 16'h0000;
      rx_cnt_reg               <= `IQD_CNT_ZERO;
      rx_tgt_reg               <= 1'b0;
      tx_addr_reg              <= 16'h0000;
      tx_cnt_reg               <= `IQD_CNT_ZERO;
      tx_tgt_reg               <= 1'b0;
    end else begin
      if (wr && idx == `IQD_A_CTRL)
        irq_global_gate_reg <= pwdata[`IQD_B_GATE];
      if (wr && idx == `IQD_A_VECT)
        vector_reg <= pwdata[7:3];
      if (wr && idx == `IQD_A_MASK) begin
        tx_mask_reg    <= pwdata[`IQD_B_TXM];
        rx_mask_reg    <= pwdata[`IQD_B_RXM];
        error_mask_reg <= pwdata[`IQD_B_ERRM];
      end
      // A block that ends drops its enable so software must re-arm the direction.
      if (last_tx)
        tx_dma_enable_reg <= 1'b0;
      else if (wr && idx == `IQD_A_MASK)
        tx_dma_enable_reg <= pwdata[`IQD_B_TXDMA];
      if (last_rx)
        rx_dma_enable_reg <= 1'b0;
      else if (wr && idx == `IQD_A_MASK)
        rx_dma_enable_reg <= pwdata[`IQD_B_RXDMA];
      tx_end_block_pending_reg <= pend_next(tx_end_block_pending_reg, wr && idx == `IQD_A_MASK,
                                            pwdata[`IQD_B_TXEOB], last_tx);
      rx_end_block_pending_reg <= pend_next(rx_end_block_pending_reg, wr && idx == `IQD_A_MASK,
                                            pwdata[`IQD_B_RXEOB], last_rx);
      // Writing a one to a pending bit also sets it, which lets software exercise the request path.
      if (wr && idx == `IQD_A_PRIO) begin
        priority_level_field_reg <= pwdata[2:0];
        dma_suspend_on_error_reg <= pwdata[`IQD_B_SUSP];
      end
      tx_pending_reg    <= pend_next(tx_pending_reg, wr && idx == `IQD_A_PRIO,
                                     pwdata[`IQD_B_TXP], tx_set);
      rx_pending_reg    <= pend_next(rx_pending_reg, wr && idx == `IQD_A_PRIO,
                                     pwdata[`IQD_B_RXP], rx_set);
      error_pending_reg <= pend_next(error_pending_reg, wr && idx == `IQD_A_PRIO,
                                     pwdata[`IQD_B_ERRP], err_set);
      // A direction enabled with a zero count wraps its counter, so software loads the count first.
      if (dma_end && busy_rx_reg) begin
        rx_addr_reg <= rx_addr_reg + `IQD_ADDR_ONE;
        rx_cnt_reg  <= rx_cnt_reg - `IQD_CNT_ONE;
      end else begin
        if (wr && idx == `IQD_A_RXADDR)
          rx_addr_reg <= pwdata[15:0];
        if (wr && idx == `IQD_A_RXCNT) begin
          rx_tgt_reg <= pwdata[`IQD_B_TGT];
          rx_cnt_reg <= cnt_load(pwdata[`IQD_B_TGT], pwdata[15:0]);
        end
      end
      if (dma_end && !busy_rx_reg) begin
        tx_addr_reg <= tx_addr_reg + `IQD_ADDR_ONE;
        tx_cnt_reg  <= tx_cnt_reg - `IQD_CNT_ONE;
      end else begin
        if (wr && idx == `IQD_A_TXADDR)
          tx_addr_reg <= pwdata[15:0];
        if (wr && idx == `IQD_A_TXCNT) begin
          tx_tgt_reg <= pwdata[`IQD_B_TGT];
          tx_cnt_reg <= cnt_load(pwdata[`IQD_B_TGT], pwdata[15:0]);
        end
      end
    end
  end

  // One transfer at a time; receive is served first so incoming data is not overrun.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cond_reg    <= 1'b0;
      tx_cond_reg    <= 1'b0;
      rx_need_reg    <= 1'b0;
      tx_need_reg    <= 1'b0;
      busy_reg       <= 1'b0;
      busy_rx_reg    <= 1'b0;
      any_event_flag <= 1'b0;
      dma_write      <= 1'b0;
      dma_to_regfile <= 1'b0;
      dma_addr       <= 16'h0000;
      dma_wdata      <= 8'h00;
      tx_byte        <= 8'h00;
      dma_byte_done  <= 1'b0;
    end else begin
      rx_cond_reg    <= rx_cond;
      tx_cond_reg    <= tx_cond;
      any_event_flag <= byte_finished_flag | err_flags;
      dma_byte_done  <= dma_end;
      if (rx_evt && rx_dma_enable_reg)
        rx_need_reg <= 1'b1;
      else if (dma_start)
        rx_need_reg <= 1'b0;
      if (tx_evt && tx_dma_enable_reg)
        tx_need_reg <= 1'b1;
      else if (dma_start && !rx_need_reg)
        tx_need_reg <= 1'b0;
      if (dma_start) begin
        busy_reg    <= 1'b1;
        busy_rx_reg <= rx_need_reg;
        if (rx_need_reg) begin
          dma_write      <= 1'b1;
          dma_to_regfile <= rx_tgt_reg;
          dma_addr       <= rx_addr_reg;
          dma_wdata      <= rx_byte;
        end else begin
          dma_write      <= 1'b0;
          dma_to_regfile <= tx_tgt_reg;
          dma_addr       <= tx_addr_reg;
        end
      end else if (dma_end) begin
        busy_reg <= 1'b0;
        if (!busy_rx_reg)
          tx_byte <= dma_rdata;
      end
    end
  end

endmodule

// >>> iqd_irq_dma_chk.sv
module iqd_irq_dma_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        irq_req,
  input wire logic [7:0]  irq_vector,
  input wire logic [2:0]  irq_level,
  input wire logic [2:0]  dma_level,
  input wire logic        dma_req,
  input wire logic        dma_ack,
  input wire logic        dma_write,
  input wire logic [15:0] dma_addr,
  input wire logic [7:0]  dma_rdata,
  input wire logic [7:0]  tx_byte,
  input wire logic        dma_byte_done,
  input wire logic        scl_hold,
  input wire logic        byte_finished_flag,
  input wire logic        any_event_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_level_off: assert property (irq_level == 3'h7 |-> !irq_req)
    else $error("request seen at the disabled level");
  chk_vector_low: assert property (irq_req |-> irq_vector[2:0] inside {3'h2, 3'h4, 3'h6})
    else $error("vector low bits wrong");
  chk_dma_level: assert property (dma_level == irq_level)
    else $error("dma level differs from interrupt level");
  chk_req_stable: assert property (dma_req && !dma_ack |=> $stable(dma_addr) && $stable(dma_write))
    else $error("dma request changed before acknowledge");
  chk_done_pulse: assert property (dma_req && dma_ack |=> dma_byte_done ##1 !dma_byte_done)
    else $error("byte done pulse missing or too long");
  chk_done_cause: assert property (dma_byte_done |-> $past(dma_req) && $past(dma_ack))
    else $error("byte done without a completed transfer");
  chk_scl_hold: assert property (dma_req |-> scl_hold)
    else $error("clock line released during a transfer");
  chk_tx_fetch: assert property (dma_req && dma_ack && !dma_write |=> tx_byte == $past(dma_rdata))
    else $error("fetched byte not stored");
  chk_event_flag: assert property (byte_finished_flag |=> any_event_flag)
    else $error("event flag missed a finished byte");
endmodule

bind iqd_irq_dma iqd_irq_dma_chk u_chk (.pclk, .presetn, .irq_req, .irq_vector, .irq_level, .dma_level,
  .dma_req, .dma_ack, .dma_write, .dma_addr, .dma_rdata, .tx_byte, .dma_byte_done, .scl_hold,
  .byte_finished_flag, .any_event_flag);

// >>> iqd_irq_dma_tb.sv
`define IQD_CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module iqd_irq_dma_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, bfin, send, err;
  logic        pready, pslverr, dma_byte_done, scl_hold, any_event_flag, irq_req;
  logic        dma_req, dma_write, dma_to_regfile, dma_ack;
  logic [7:0]  paddr, rx_byte, fetch_byte, irq_vector, tx_byte, dma_wdata, dma_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dma_addr;
  logic [8:0]  eflags;
  logic [3:0]  ack_delay;
  logic [2:0]  irq_level, dma_level;
  int          num_errors, cmp_count, cycles;

  iqd_irq_dma u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .byte_finished_flag(bfin), .direction_send_flag(send), .slave_match_flag(eflags[0]),
    .start_sent_flag(eflags[1]), .no_ack_flag(eflags[2]), .stop_seen_flag(eflags[3]),
    .lost_bus_flag(eflags[4]), .bus_fault_flag(eflags[5]), .header_sent_flag(eflags[6]),
    .master_addr_sent_flag(eflags[7]), .clock_line_flag(eflags[8]), .rx_byte(rx_byte),
    .tx_byte(tx_byte), .dma_byte_done(dma_byte_done), .scl_hold(scl_hold),
    .any_event_flag(any_event_flag), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .dma_req(dma_req), .dma_write(dma_write), .dma_to_regfile(dma_to_regfile), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_level(dma_level), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
  iqd_dma_partner u_partner (.pclk(pclk), .presetn(presetn), .dma_req(dma_req), .ack_delay(ack_delay),
    .fetch_byte(fetch_byte), .dma_ack(dma_ack), .dma_rdata(dma_rdata));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("Mismatches %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end

  // Every driver starts on a rising edge and returns at a falling edge, where outputs are settled.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic pulse(input logic s);
    @(posedge pclk);
    send <= s;
    bfin <= 1'b1;
    @(posedge pclk);
    bfin <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wait_on(input int which);
    for (int i = 0; i < 60 && (which ? dma_byte_done : dma_req) !== 1'b1; i++) @(negedge pclk);
  endtask

  task automatic t_regs;
    apb(0, 8'h0C, 32'h0);
    `IQD_CHK("prio_reset", 32'h00000080, rd)
    `IQD_CHK("ready", 1'b1, pready)
    apb(0, 8'h40, 32'h0);
    `IQD_CHK("unmapped", 1'b1, err)
    `IQD_CHK("unmapped_rd", 32'h00000000, rd)
    apb(1, 8'h01, 32'h1);
    `IQD_CHK("unaligned", 1'b1, err)
    apb(0, 8'h00, 32'h0);
    `IQD_CHK("gate_kept", 32'h00000000, rd)
    apb(1, 8'h14, 32'h800000FF);
    apb(0, 8'h14, 32'h0);
    `IQD_CHK("rf_count_max", 32'h800000DE, rd)
    apb(1, 8'h1C, 32'h0);
    apb(0, 8'h1C, 32'h0);
    `IQD_CHK("mem_count_max", 32'h00010000, rd)
  endtask

  task automatic t_rx_irq;
    apb(1, 8'h04, 32'hA8);
    apb(1, 8'h08, 32'h2);
    pulse(1'b0);
    `IQD_CHK("gate_off", 1'b0, irq_req)
    apb(1, 8'h00, 32'h1);
    pulse(1'b0);
    `IQD_CHK("rx_req", 1'b1, irq_req)
    `IQD_CHK("rx_vector", 8'hAC, irq_vector)
    apb(1, 8'h0C, 32'h97);
    `IQD_CHK("level_off", 1'b0, irq_req)
    `IQD_CHK("irq_level", 3'h7, irq_level)
    `IQD_CHK("dma_level", 3'h7, dma_level)
    apb(1, 8'h0C, 32'h90);
    `IQD_CHK("still_pending", 1'b1, irq_req)
    apb(1, 8'h0C, 32'h80);
    `IQD_CHK("cleared", 1'b0, irq_req)
  endtask

  task automatic t_err;
    apb(1, 8'h08, 32'h7);
    pulse(1'b1);
    `IQD_CHK("tx_vector", 8'hAE, irq_vector)
    for (int i = 0; i < 9; i++) begin
      @(posedge pclk);
      eflags <= 9'h001 << i;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      `IQD_CHK("err_vector", 8'hAA, irq_vector)
      `IQD_CHK("event_flag", 1'b1, any_event_flag)
      @(posedge pclk);
      eflags <= 9'h000;
      apb(1, 8'h0C, 32'h88);
      `IQD_CHK("err_cleared", 8'hAE, irq_vector)
    end
    apb(1, 8'h0C, 32'h80);
  endtask

  task automatic t_dma_rx;
    ack_delay <= 4'h3;
    apb(1, 8'h10, 32'h40);
    apb(1, 8'h14, 32'h80000002);
    apb(1, 8'h08, 32'h12);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk);
      rx_byte <= 8'h5A + k[7:0];
      pulse(1'b0);
      wait_on(0);
      `IQD_CHK("rx_addr", 16'h0040 + k[15:0], dma_addr)
      `IQD_CHK("rx_dir", 2'b11, {dma_write, dma_to_regfile})
      `IQD_CHK("rx_data", 8'h5A + k[7:0], dma_wdata)
      `IQD_CHK("rx_no_irq", 1'b0, irq_req)
      wait_on(1);
      `IQD_CHK("rx_done", 1'b1, dma_byte_done)
    end
    `IQD_CHK("eob_no_event", 1'b0, any_event_flag)
    @(negedge pclk);
    `IQD_CHK("rx_eob_vec", 8'hAC, irq_vector)
    apb(0, 8'h08, 32'h0);
    `IQD_CHK("rx_eob_mask", 32'h00000042, rd)
    apb(0, 8'h14, 32'h0);
    `IQD_CHK("rx_count", 32'h80000000, rd)
    apb(0, 8'h0C, 32'h0);
    `IQD_CHK("rx_no_pend", 32'h00000080, rd)
    apb(1, 8'h08, 32'h0);
  endtask

  task automatic t_dma_tx;
    ack_delay <= 4'h0;
    fetch_byte <= 8'hC3;
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h18, 32'h1234);
    apb(1, 8'h1C, 32'h1);
    apb(1, 8'h0C, 32'hA0);
    apb(1, 8'h08, 32'h9);
    pulse(1'b1);
    repeat (3) @(negedge pclk);
    `IQD_CHK("suspended", 2'b01, {dma_req, scl_hold})
    `IQD_CHK("err_masked", 1'b0, irq_req)
    apb(1, 8'h0C, 32'h80);
    wait_on(0);
    `IQD_CHK("tx_addr", 16'h1234, dma_addr)
    `IQD_CHK("tx_dir", 2'b00, {dma_write, dma_to_regfile})
    wait_on(1);
    @(negedge pclk);
    `IQD_CHK("tx_byte", 8'hC3, tx_byte)
    `IQD_CHK("tx_eob_req", 1'b1, irq_req)
    `IQD_CHK("tx_eob_vec", 8'hAE, irq_vector)
    apb(0, 8'h08, 32'h0);
    `IQD_CHK("tx_eob_mask", 32'h00000021, rd)
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, bfin, send} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_byte = 8'h00;
    fetch_byte = 8'h00;
    eflags = 9'h000;
    ack_delay = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rx_irq;
    t_err;
    t_dma_rx;
    t_dma_tx;
    report_and_stop;
  end
endmodule
